// ---- rtl/rcc_curve_config.sv ----
// register bank and curve parameter decode for range_compressor_one
// assumes single-cycle word writes/reads on the register port and enables from the neighbouring control register
`timescale 1ns/10ps
//
// Overview of operation
// - gate minimum gain code 1..12 decodes -30 dB to 36 dB in 6 dB steps
// - gate minimum gain code 0 is -36 dB and the field resets to 0
// - gate expansion slope code selects ratio 1, 2, 4 or 8, resets to 0
// - fast release threshold 12..30 dB, decay 0.725, 1.45 or 5.8 ms, both reset to 0
// - upper slope 1 down to 1/16 or zero, resets to 011, 110 and 111 reserved
// - lower slope 1 down to 1/8 or zero, resets to 000, 101 and 11x reserved
// - main knee input 0 dB down to -45 dB in 0.75 dB steps
// - main knee output 0 dB down to -22.5 dB in 0.75 dB steps
// - gate knee levels in 1.5 dB steps; output only used while its enable is set
module rcc_curve_config
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic noise_gate_enable_in,
    input wire logic gate_knee_out_enable_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic signed [15:0] gate_min_gain_out,
    output logic [1:0] gate_expansion_shift_out,
    output logic [7:0] fast_release_threshold_db_out,
    output logic [15:0] fast_release_decay_us_out,
    output logic [2:0] upper_compress_shift_out,
    output logic upper_compress_zero_out,
    output logic [2:0] lower_compress_shift_out,
    output logic lower_compress_zero_out,
    output logic signed [15:0] main_knee_in_level_out,
    output logic signed [15:0] main_knee_out_level_out,
    output logic signed [15:0] gate_knee_in_level_out,
    output logic signed [15:0] gate_knee_out_level_out,
    output logic gate_knee_in_active_out,
    output logic gate_knee_out_active_out,
    output logic cfg_reserved_out
);
    import rcc_pkg::*;

    logic [15:0] gate_release_q;
    logic [15:0] main_knee_q;
    logic [15:0] gate_knee_q;

    logic sel_gate_release;
    logic sel_main_knee;
    logic sel_gate_knee;
    logic [15:0] rdata_d;

    logic [3:0] gate_min_gain;
    logic [1:0] gate_expansion_slope;
    logic [1:0] fast_release_threshold;
    logic [1:0] fast_release_decay;
    logic [2:0] upper_compress_slope;
    logic [2:0] lower_compress_slope;
    logic [5:0] main_knee_in_level;
    logic [4:0] main_knee_out_level;
    logic [4:0] gate_knee_in_level;
    logic [4:0] gate_knee_out_level;

    logic [7:0] thr_db_d;
    logic [15:0] dcy_us_d;
    logic [2:0] hi_shift_d;
    logic hi_zero_d;
    logic [2:0] lo_shift_d;
    logic lo_zero_d;
    logic reserved_d;
    logic [5:0] lvl_code [RCC_NUM_LVL];
    logic signed [15:0] lvl_value [RCC_NUM_LVL];

    // address decode; unmapped addresses write nothing and read zero
    assign sel_gate_release = (reg_addr_in == RCC_ADDR_GATE_RELEASE);
    assign sel_main_knee = (reg_addr_in == RCC_ADDR_MAIN_KNEE);
    assign sel_gate_knee = (reg_addr_in == RCC_ADDR_GATE_KNEE);
    assign rdata_d = sel_gate_release ? gate_release_q :
                     sel_main_knee ? main_knee_q :
                     sel_gate_knee ? gate_knee_q : 16'h0000;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gate_release_q <= RCC_RST_GATE_RELEASE;
            main_knee_q <= RCC_RST_MAIN_KNEE;
            gate_knee_q <= RCC_RST_GATE_KNEE;
        end
        else if (reg_wr_in)
        begin
            if (sel_gate_release)
                gate_release_q <= reg_wdata_in & RCC_MASK_GATE_RELEASE;
            if (sel_main_knee)
                main_knee_q <= reg_wdata_in & RCC_MASK_MAIN_KNEE;
            if (sel_gate_knee)
                gate_knee_q <= reg_wdata_in & RCC_MASK_GATE_KNEE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rdata_out <= reg_rd_in ? rdata_d : 16'h0000;
            reg_rvalid_out <= reg_rd_in;
        end
    end

    // field extraction
    assign gate_min_gain = gate_release_q[RCC_MIN_GAIN_LSB +: 4];
    assign gate_expansion_slope = gate_release_q[RCC_EXP_LSB +: 2];
    assign fast_release_threshold = gate_release_q[RCC_THR_LSB +: 2];
    assign fast_release_decay = gate_release_q[RCC_DCY_LSB +: 2];
    assign upper_compress_slope = gate_release_q[RCC_HI_LSB +: 3];
    assign lower_compress_slope = gate_release_q[RCC_LO_LSB +: 3];
    assign main_knee_in_level = main_knee_q[RCC_KNEE_IN_LSB +: 6];
    assign main_knee_out_level = main_knee_q[RCC_KNEE_OUT_LSB +: 5];
    assign gate_knee_in_level = gate_knee_q[RCC_KNEE_IN_LSB +: 5];
    assign gate_knee_out_level = gate_knee_q[RCC_KNEE_OUT_LSB +: 5];

    assign lvl_code[RCC_LVL_MIN_GAIN] = {2'h0, gate_min_gain};
    assign lvl_code[RCC_LVL_KNEE_IN] = main_knee_in_level;
    assign lvl_code[RCC_LVL_KNEE_OUT] = {1'b0, main_knee_out_level};
    assign lvl_code[RCC_LVL_GATE_IN] = {1'b0, gate_knee_in_level};
    assign lvl_code[RCC_LVL_GATE_OUT] = {1'b0, gate_knee_out_level};

    // all level fields are linear in the code, so one decoder shape covers them
    genvar g;
    generate
        for (g = 0; g < RCC_NUM_LVL; g = g + 1)
        begin : gen_lvl
            rcc_lin_decode #(
                .BASE(RCC_LVL_BASE[g]),
                .STEP(RCC_LVL_STEP[g])
            ) u_dec (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .code_in(lvl_code[g]),
                .level_out(lvl_value[g])
            );
        end
    endgenerate

    assign gate_min_gain_out = lvl_value[RCC_LVL_MIN_GAIN];
    assign main_knee_in_level_out = lvl_value[RCC_LVL_KNEE_IN];
    assign main_knee_out_level_out = lvl_value[RCC_LVL_KNEE_OUT];
    assign gate_knee_in_level_out = lvl_value[RCC_LVL_GATE_IN];
    assign gate_knee_out_level_out = lvl_value[RCC_LVL_GATE_OUT];

    assign thr_db_d = 8'(RCC_THR_BASE_DB + RCC_THR_STEP_DB * {6'h00, fast_release_threshold});
    assign dcy_us_d = (fast_release_decay == 2'h1) ? RCC_DCY_01_US :
                      (fast_release_decay == 2'h2) ? RCC_DCY_10_US : RCC_DCY_00_US;
    // slopes are powers of two, so the gain stage shifts instead of multiplying
    assign hi_zero_d = (upper_compress_slope == RCC_HI_ZERO);
    assign hi_shift_d = hi_zero_d ? 3'h0 : upper_compress_slope;
    assign lo_zero_d = (lower_compress_slope == RCC_LO_ZERO);
    assign lo_shift_d = lo_zero_d ? 3'h0 : lower_compress_slope;

    // reserved codes are flagged only; software is trusted to avoid them
    assign reserved_d = (gate_min_gain > RCC_MIN_GAIN_MAX)
                      || (fast_release_decay == RCC_DCY_RSVD)
                      || (upper_compress_slope > RCC_HI_ZERO)
                      || (lower_compress_slope > RCC_LO_ZERO)
                      || (main_knee_in_level > RCC_KNEE_IN_MAX)
                      || (main_knee_out_level == RCC_KNEE_OUT_RSVD);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gate_expansion_shift_out <= 2'h0;
            fast_release_threshold_db_out <= 8'h00;
            fast_release_decay_us_out <= 16'h0000;
            upper_compress_shift_out <= 3'h0;
            upper_compress_zero_out <= 1'b0;
            lower_compress_shift_out <= 3'h0;
            lower_compress_zero_out <= 1'b0;
            gate_knee_in_active_out <= 1'b0;
            gate_knee_out_active_out <= 1'b0;
            cfg_reserved_out <= 1'b0;
        end
        else
        begin
            gate_expansion_shift_out <= gate_expansion_slope;
            fast_release_threshold_db_out <= thr_db_d;
            fast_release_decay_us_out <= dcy_us_d;
            upper_compress_shift_out <= hi_shift_d;
            upper_compress_zero_out <= hi_zero_d;
            lower_compress_shift_out <= lo_shift_d;
            lower_compress_zero_out <= lo_zero_d;
            gate_knee_in_active_out <= noise_gate_enable_in;
            gate_knee_out_active_out <= gate_knee_out_enable_in;
            cfg_reserved_out <= reserved_d;
        end
    end

    chk_min_gain_top: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gate_min_gain == 4'h1) |=> (gate_min_gain_out == -16'sd120))
        else $error("gate min gain code 1 not -30 dB");
    chk_min_gain_max: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gate_min_gain == 4'hc) |=> (gate_min_gain_out == 16'sd144))
        else $error("gate min gain code 12 not 36 dB");
    // the flag is shared by several fields, so only the reserved side of min gain, decay and upper slope is asserted on it
    chk_min_gain_rsvd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gate_min_gain > RCC_MIN_GAIN_MAX) |=> cfg_reserved_out)
        else $error("gate min gain reserved code not flagged");
    chk_min_gain_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gate_min_gain == 4'h0) |=> (gate_min_gain_out == -16'sd144))
        else $error("gate min gain code 0 not -36 dB");
    chk_expansion_ratio: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_wr_in && sel_gate_release) |=> ##1 (gate_expansion_shift_out == $past(reg_wdata_in[11:10], 2)))
        else $error("expansion slope not taken from write");
    chk_release_threshold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (fast_release_threshold == 2'h3) |=> (fast_release_threshold_db_out == 8'd30))
        else $error("fast release threshold code 3 not 30 dB");
    chk_release_decay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (fast_release_decay == 2'h2) |=> (fast_release_decay_us_out == 16'd5800))
        else $error("fast release decay code 2 not 5.8 ms");
    chk_decay_rsvd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (fast_release_decay == RCC_DCY_RSVD) |=> cfg_reserved_out)
        else $error("fast release decay reserved code not flagged");
    chk_upper_slope: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (upper_compress_slope == 3'h5) |=> upper_compress_zero_out ##0 (upper_compress_shift_out == 3'h0))
        else $error("upper slope code 5 not zero");
    chk_upper_rsvd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (upper_compress_slope[2:1] == 2'h3) |=> cfg_reserved_out)
        else $error("upper slope reserved code not flagged");
    chk_lower_slope: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (lower_compress_slope == 3'h2) |=> (lower_compress_shift_out == 3'h2) && !lower_compress_zero_out)
        else $error("lower slope code 2 not 1/4");
    chk_lower_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (lower_compress_slope == 3'h4) |=> lower_compress_zero_out)
        else $error("lower slope code 4 not zero");
    chk_knee_in_floor: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (main_knee_in_level == 6'h3c) |=> (main_knee_in_level_out == -16'sd180))
        else $error("main knee input 0x3c not -45 dB");
    chk_knee_out_floor: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (main_knee_out_level == 5'h1e) |=> (main_knee_out_level_out == -16'sd90))
        else $error("main knee output 0x1e not -22.5 dB");
    chk_gate_knee_in: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gate_knee_in_level == 5'h1f) |=> (gate_knee_in_level_out == -16'sd330))
        else $error("gate knee input 0x1f not -82.5 dB");
    chk_gate_knee_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (gate_knee_out_level == 5'h1f && gate_knee_out_enable_in) |=>
        (gate_knee_out_level_out == -16'sd306) && gate_knee_out_active_out)
        else $error("gate knee output 0x1f not -76.5 dB or not active");
endmodule : rcc_curve_config

// ---- rtl/rcc_lin_decode.sv ----
// registered linear decode of a level code: base plus step times code
// assumes code is stable between register writes; one cycle latency
`timescale 1ns/10ps
module rcc_lin_decode
#(
    parameter logic signed [15:0] BASE = 16'sd0,
    parameter logic signed [15:0] STEP = 16'sd1
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [5:0] code_in,
    output logic signed [15:0] level_out
);
    logic signed [15:0] level_d;
    logic signed [15:0] code_s;

    assign code_s = $signed({10'h000, code_in});
    assign level_d = 16'(BASE + STEP * code_s);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            level_out <= 16'sh0000;
        else
            level_out <= level_d;
    end
endmodule : rcc_lin_decode

// ---- rtl/rcc_pkg.sv ----
// constants for the first range compressor curve configuration block
// assumes a 16-bit word-addressed register port with one-cycle write and read strobes
package rcc_pkg;

    localparam logic [15:0] RCC_ADDR_GATE_RELEASE = 16'h0e82;
    localparam logic [15:0] RCC_ADDR_MAIN_KNEE = 16'h0e83;
    localparam logic [15:0] RCC_ADDR_GATE_KNEE = 16'h0e84;

    localparam logic [15:0] RCC_RST_GATE_RELEASE = 16'h0018;
    localparam logic [15:0] RCC_RST_MAIN_KNEE = 16'h0000;
    localparam logic [15:0] RCC_RST_GATE_KNEE = 16'h0000;

    // field positions in gate_release_slope_settings
    localparam int RCC_MIN_GAIN_LSB = 12;
    localparam int RCC_EXP_LSB = 10;
    localparam int RCC_THR_LSB = 8;
    localparam int RCC_DCY_LSB = 6;
    localparam int RCC_HI_LSB = 3;
    localparam int RCC_LO_LSB = 0;
    // field positions in the knee registers
    localparam int RCC_KNEE_IN_LSB = 5;
    localparam int RCC_KNEE_OUT_LSB = 0;

    // implemented bits of each register, the rest read as zero
    localparam logic [15:0] RCC_MASK_GATE_RELEASE = 16'hffff;
    localparam logic [15:0] RCC_MASK_MAIN_KNEE = 16'h07ff;
    localparam logic [15:0] RCC_MASK_GATE_KNEE = 16'h03ff;

    // linear level decoders, levels in signed quarter-dB units
    localparam int RCC_NUM_LVL = 5;
    localparam int RCC_LVL_MIN_GAIN = 0;
    localparam int RCC_LVL_KNEE_IN = 1;
    localparam int RCC_LVL_KNEE_OUT = 2;
    localparam int RCC_LVL_GATE_IN = 3;
    localparam int RCC_LVL_GATE_OUT = 4;
    localparam logic signed [15:0] RCC_LVL_BASE [RCC_NUM_LVL] = '{-16'sd144, 16'sd0, 16'sd0, -16'sd144, -16'sd120};
    localparam logic signed [15:0] RCC_LVL_STEP [RCC_NUM_LVL] = '{16'sd24, -16'sd3, -16'sd3, -16'sd6, -16'sd6};

    // reserved code limits
    localparam logic [3:0] RCC_MIN_GAIN_MAX = 4'hc;
    localparam logic [5:0] RCC_KNEE_IN_MAX = 6'h3c;
    localparam logic [4:0] RCC_KNEE_OUT_RSVD = 5'h1f;
    localparam logic [1:0] RCC_DCY_RSVD = 2'h3;
    localparam logic [2:0] RCC_HI_ZERO = 3'h5;
    localparam logic [2:0] RCC_LO_ZERO = 3'h4;

    // fast release threshold in dB: base plus step per code
    localparam logic [7:0] RCC_THR_BASE_DB = 8'h0c;
    localparam logic [7:0] RCC_THR_STEP_DB = 8'h06;

    // fast release decay times in microseconds
    localparam logic [15:0] RCC_DCY_00_US = 16'd725;
    localparam logic [15:0] RCC_DCY_01_US = 16'd1450;
    localparam logic [15:0] RCC_DCY_10_US = 16'd5800;

endpackage : rcc_pkg

// ---- test/rcc_curve_config_tb.sv ----
// self-checking bench for the range compressor curve configuration block
// assumes one-cycle register strobes, read data one cycle after the strobe, decode one cycle after a write
`timescale 1ns/10ps
module rcc_curve_config_tb;
    import rcc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic noise_gate_enable_in = 1'b0;
    logic gate_knee_out_enable_in = 1'b0;
    logic [15:0] rdata, gmg, dcy, mkin, mkout, gkin, gkout, w, seed;
    logic [7:0] thr;
    logic [2:0] hish, losh;
    logic [1:0] gexp;
    logic rvalid, hiz, loz, gkin_act, gkout_act, rsvd;
    logic rsv_exp;
    logic [15:0] rd_q [$];
    int n_mismatch = 0;
    int checked = 0;

    rcc_curve_config dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .noise_gate_enable_in(noise_gate_enable_in), .gate_knee_out_enable_in(gate_knee_out_enable_in),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .gate_min_gain_out(gmg),
        .gate_expansion_shift_out(gexp), .fast_release_threshold_db_out(thr), .fast_release_decay_us_out(dcy),
        .upper_compress_shift_out(hish), .upper_compress_zero_out(hiz), .lower_compress_shift_out(losh),
        .lower_compress_zero_out(loz), .main_knee_in_level_out(mkin), .main_knee_out_level_out(mkout),
        .gate_knee_in_level_out(gkin), .gate_knee_out_level_out(gkout), .gate_knee_in_active_out(gkin_act),
        .gate_knee_out_active_out(gkout_act), .cfg_reserved_out(rsvd));

    always #5 clk_in = ~clk_in;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    // the expected word is noted when the strobe goes out, the monitor pairs it with rvalid
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        rd_q.push_back(exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
    endtask : rd

    // sampled on the falling edge so the registered pulse is settled
    always @(negedge clk_in)
    begin
        if (rvalid === 1'b1)
        begin
            if (rd_q.size() == 0)
                chk("unexpected read", 16'h0000, 16'hffff);
            else
                chk("read data", rd_q.pop_front(), rdata);
        end
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial
    begin
        seed = 16'h002e;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        @(posedge clk_in);
        #1;
        chk("min gain", 16'hff70, gmg);
        chk("expansion", 16'h0000, 16'(gexp));
        chk("threshold", 16'h000c, 16'(thr));
        chk("decay", 16'd725, dcy);
        chk("reserved", 16'h0000, 16'(rsvd));
        chk("gate actives", 16'h0000, 16'({gkin_act, gkout_act}));
        chk("upper slope", 16'h0003, 16'({hiz, hish}));
        chk("lower slope", 16'h0000, 16'({loz, losh}));
        chk("knee levels", 16'h0000, mkin | mkout);
        chk("gate knee in", 16'hff70, gkin);
        chk("gate knee out", 16'hff88, gkout);
        rd(RCC_ADDR_GATE_RELEASE, 16'h0018);
        rd(RCC_ADDR_MAIN_KNEE, 16'h0000);
        rd(RCC_ADDR_GATE_KNEE, 16'h0000);
        $display("test reset values done");
        // one sweep sets every code of every gate/slope field except decay code 00, reserved ones included
        for (int i = 0; i < 16; i++)
        begin
            w = {4'(i), 2'(i), 2'(i + 1), 2'(i % 3 + 1), 3'(i), 3'(i + 3)};
            wr(RCC_ADDR_GATE_RELEASE, w);
            @(posedge clk_in);
            #1;
            if (w[15:12] <= 4'hc)
                chk("min gain", 16'(-144 + 24 * int'(w[15:12])), gmg);
            chk("expansion", 16'(w[11:10]), 16'(gexp));
            chk("threshold", 16'(12 + 6 * int'(w[9:8])), 16'(thr));
            if (w[7:6] != 2'h3)
                chk("decay", (w[7:6] == 2'h1) ? 16'd1450 : 16'd5800, dcy);
            if (w[5:3] < 3'h6)
                chk("upper slope", 16'({w[5:3] == 3'h5, (w[5:3] == 3'h5) ? 3'h0 : w[5:3]}), 16'({hiz, hish}));
            if (w[2:0] < 3'h5)
                chk("lower slope", 16'({w[2:0] == 3'h4, (w[2:0] == 3'h4) ? 3'h0 : w[2:0]}), 16'({loz, losh}));
            rsv_exp = w[15:12] > 4'hc || w[7:6] == 2'h3 || w[5:3] > 3'h5 || w[2:0] > 3'h4;
            chk("reserved", 16'(rsv_exp), 16'(rsvd));
            rd(RCC_ADDR_GATE_RELEASE, w);
        end
        $display("test gate and slope codes done");
        // back to legal codes before the knee scenario, so only knee fields can raise the flag
        wr(RCC_ADDR_GATE_RELEASE, 16'h0018);
        // random knee words also hit the unimplemented bits, but none of the 12 main knee words holds a reserved knee code
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            w = seed;
            wr(RCC_ADDR_MAIN_KNEE, w);
            noise_gate_enable_in <= w[15];
            gate_knee_out_enable_in <= w[14];
            seed = lfsr(seed);
            wr(RCC_ADDR_GATE_KNEE, seed);
            @(posedge clk_in);
            #1;
            if (w[10:5] <= 6'h3c)
                chk("knee in", 16'(-3 * int'(w[10:5])), mkin);
            if (w[4:0] != 5'h1f)
                chk("knee out", 16'(-3 * int'(w[4:0])), mkout);
            chk("reserved", 16'(w[10:5] > 6'h3c || w[4:0] == 5'h1f), 16'(rsvd));
            chk("gate knee in", 16'(-144 - 6 * int'(seed[9:5])), gkin);
            chk("gate knee out", 16'(-120 - 6 * int'(seed[4:0])), gkout);
            chk("gate actives", 16'({w[15], w[14]}), 16'({gkin_act, gkout_act}));
            rd(RCC_ADDR_MAIN_KNEE, w & 16'h07ff);
            rd(RCC_ADDR_GATE_KNEE, seed & 16'h03ff);
        end
        $display("test knee levels done");
        w = seed & 16'h03ff;
        wr(16'h0e85, 16'hffff);
        rd(16'h0e85, 16'h0000);
        rd(RCC_ADDR_GATE_KNEE, w);
        for (int k = 0; k < 10 && rd_q.size() > 0; k++)
            @(posedge clk_in);
        if (rd_q.size() != 0)
            n_mismatch++;
        $display("test unmapped address done");
        final_report();
    end
endmodule : rcc_curve_config_tb
